// File: verilog/pss_sram_ctrl.v
// Purpose : Control decode and pipeline of a 64K x 18 pipelined synchronous SRAM
// Assumes : All pins synchronous to i_ref_clk; data bus split into in, out, enable
// Notes   : Burst address sequencing is not modelled; every strobe loads a new address
//
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`include "pss_map.vh"

module pss_sram_ctrl #(
  parameter LANE_W = `PSS_LANE_W,
  parameter LANES  = `PSS_LANES,
  parameter ADDR_W = `PSS_ADDR_W
) (
  input  wire                     i_ref_clk,
  input  wire                     i_srst,
  // Memory pins
  input  wire [ADDR_W-1:0]        i_addr,
  input  wire [LANE_W*LANES-1:0]  i_dq,
  output wire [LANE_W*LANES-1:0]  o_dq,
  output wire                     o_dq_oe,
  input  wire                     i_output_enable_n,
  input  wire                     i_all_lanes_write_n,
  input  wire                     i_write_qualifier_n,
  input  wire [LANES-1:0]         i_byte_lane_write_n,
  input  wire                     i_select_one_n,
  input  wire                     i_select_two,
  input  wire                     i_select_three_n,
  input  wire                     i_cpu_addr_strobe_n,
  input  wire                     i_ctrl_addr_strobe_n,
  input  wire                     i_burst_advance_n,
  input  wire                     i_burst_order_select_n,
  // AXI4-Lite slave
  input  wire [`PSS_AXI_AW-1:0]   i_s_axi_awaddr,
  input  wire                     i_s_axi_awvalid,
  output wire                     o_s_axi_awready,
  input  wire [31:0]              i_s_axi_wdata,
  input  wire [3:0]               i_s_axi_wstrb,
  input  wire                     i_s_axi_wvalid,
  output wire                     o_s_axi_wready,
  output wire [1:0]               o_s_axi_bresp,
  output wire                     o_s_axi_bvalid,
  input  wire                     i_s_axi_bready,
  input  wire [`PSS_AXI_AW-1:0]   i_s_axi_araddr,
  input  wire                     i_s_axi_arvalid,
  output wire                     o_s_axi_arready,
  output wire [31:0]              o_s_axi_rdata,
  output wire [1:0]               o_s_axi_rresp,
  output wire                     o_s_axi_rvalid,
  input  wire                     i_s_axi_rready
);

  localparam DW = LANE_W * LANES;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg  [ADDR_W-1:0]        addr_reg;
  reg  [DW-1:0]            din_reg;
  reg                      sel_reg;
  reg                      wr_reg;
  reg  [LANES-1:0]         lanes_reg;
  reg                      rd_pend_reg;
  reg  [DW-1:0]            dq_reg;
  reg                      oe_reg;
  reg                      ctrl_en_reg;
  reg  [31:0]              rd_count_reg;
  reg  [31:0]              wr_count_reg;
  reg                      awready_reg;
  reg  [`PSS_AXI_AW-1:0]   aw_addr_reg;
  reg                      wready_reg;
  reg  [31:0]              w_data_reg;
  reg  [3:0]               w_strb_reg;
  reg                      bvalid_reg;
  reg  [1:0]               bresp_reg;
  reg                      rvalid_reg;
  reg  [31:0]              rdata_reg;
  reg  [1:0]               rresp_reg;
  reg                      arready_reg;
  wire                     addr_strobe;
  wire                     chip_en;
  wire                     is_write;
  wire [LANES-1:0]         lane_we_pin;
  wire [LANES-1:0]         ram_we;
  wire [DW-1:0]            ram_rdata;
  wire                     write_now;
  wire                     clear_req;
  wire                     do_write;
  wire [31:0]              status_word;

  // ----------------------------------------------------------------
  // Pin decode
  // ----------------------------------------------------------------
  // Either strobe low opens a new cycle; the non-burst tie holds one low
  assign addr_strobe = ~i_cpu_addr_strobe_n | ~i_ctrl_addr_strobe_n;
  assign chip_en     = ~i_select_one_n & i_select_two & ~i_select_three_n;
  // Global write covers every lane; otherwise only the lanes asked for
  assign is_write    = ~i_all_lanes_write_n |
                       (~i_write_qualifier_n & ~(&i_byte_lane_write_n));
  assign lane_we_pin = ~i_all_lanes_write_n ? {LANES{1'b1}} :
                       (~i_write_qualifier_n ? ~i_byte_lane_write_n : {LANES{1'b0}});

  // ----------------------------------------------------------------
  // Input register stage
  // ----------------------------------------------------------------
  // Address only moves on a strobe; write controls and data every clock
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      addr_reg  <= {ADDR_W{1'b0}};
      din_reg   <= {DW{1'b0}};
      sel_reg   <= 1'b0;
      wr_reg    <= 1'b0;
      lanes_reg <= {LANES{1'b0}};
    end else begin
      din_reg   <= i_dq;
      wr_reg    <= is_write;
      lanes_reg <= lane_we_pin;
      if (addr_strobe) begin
        addr_reg <= i_addr;
        sel_reg  <= chip_en & ctrl_en_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Array stage
  // ----------------------------------------------------------------
  assign write_now = sel_reg & wr_reg;
  assign ram_we    = lanes_reg & {LANES{write_now}};

  pss_lane_ram #(
    .LANE_W (LANE_W),
    .LANES  (LANES),
    .ADDR_W (ADDR_W)
  ) u_ram (
    .i_ref_clk (i_ref_clk),
    .i_addr    (addr_reg),
    .i_lane_we (ram_we),
    .i_wdata   (din_reg),
    .o_rdata   (ram_rdata)
  );

  // ----------------------------------------------------------------
  // Output register stage
  // ----------------------------------------------------------------
  // Extra register costs a clock of latency but shortens clock-to-data
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      rd_pend_reg <= 1'b0;
      dq_reg      <= {DW{1'b0}};
      oe_reg      <= 1'b0;
    end else begin
      rd_pend_reg <= sel_reg & ~wr_reg;
      if (rd_pend_reg) begin
        dq_reg <= ram_rdata;
      end
      // A write in flight masks output enable so the bus is left to the writer
      oe_reg <= rd_pend_reg & ~i_output_enable_n & ~write_now;
    end
  end

  assign o_dq    = dq_reg;
  assign o_dq_oe = oe_reg;

  // ----------------------------------------------------------------
  // Activity counters
  // ----------------------------------------------------------------
  // Clear and count in one cycle leaves a count of one, so no event is lost
  assign clear_req = do_write && (aw_addr_reg == `PSS_OFF_CTRL) &&
                     w_strb_reg[0] && w_data_reg[`PSS_CTRL_CLEAR];
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      rd_count_reg <= 32'h0000_0000;
      wr_count_reg <= 32'h0000_0000;
    end else begin
      if (clear_req) begin
        rd_count_reg <= {31'h0000_0000, sel_reg & ~wr_reg};
        wr_count_reg <= {31'h0000_0000, write_now};
      end else begin
        rd_count_reg <= rd_count_reg + {31'h0000_0000, sel_reg & ~wr_reg};
        wr_count_reg <= wr_count_reg + {31'h0000_0000, write_now};
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  // Address and data are held separately so either may come first
  assign do_write = ~awready_reg & ~wready_reg & ~bvalid_reg;
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      awready_reg <= 1'b1;
      aw_addr_reg <= {`PSS_AXI_AW{1'b0}};
      wready_reg  <= 1'b1;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `PSS_RESP_OKAY;
      ctrl_en_reg <= `PSS_CTRL_RESET;
    end else begin
      if (i_s_axi_awvalid && awready_reg) begin
        awready_reg <= 1'b0;
        aw_addr_reg <= i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && wready_reg) begin
        wready_reg <= 1'b0;
        w_data_reg <= i_s_axi_wdata;
        w_strb_reg <= i_s_axi_wstrb;
      end
      if (do_write) begin
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
        bvalid_reg  <= 1'b1;
        case (aw_addr_reg)
          `PSS_OFF_CTRL: begin
            bresp_reg <= `PSS_RESP_OKAY;
            if (w_strb_reg[0]) begin
              ctrl_en_reg <= w_data_reg[`PSS_CTRL_ENABLE];
            end
          end
          `PSS_OFF_STATUS, `PSS_OFF_RDCOUNT, `PSS_OFF_WRCOUNT: begin
            bresp_reg <= `PSS_RESP_OKAY;
          end
          default: begin
            bresp_reg <= `PSS_RESP_SLVERR;
          end
        endcase
      end else if (bvalid_reg && i_s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Ready is low while a word is held, which stalls the master honestly
  assign o_s_axi_awready = awready_reg;
  assign o_s_axi_wready  = wready_reg;
  assign o_s_axi_bvalid  = bvalid_reg;
  assign o_s_axi_bresp   = bresp_reg;

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  // Burst order pin is shown for board checks only; it steers nothing
  assign status_word = {28'h000_0000, i_burst_advance_n, i_burst_order_select_n,
                        wr_reg, sel_reg};
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      rvalid_reg  <= 1'b0;
      arready_reg <= 1'b1;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= `PSS_RESP_OKAY;
    end else begin
      if (i_s_axi_arvalid && arready_reg) begin
        rvalid_reg  <= 1'b1;
        arready_reg <= 1'b0;
        rresp_reg  <= `PSS_RESP_OKAY;
        case (i_s_axi_araddr)
          `PSS_OFF_CTRL:    rdata_reg <= {31'h0000_0000, ctrl_en_reg};
          `PSS_OFF_STATUS:  rdata_reg <= status_word;
          `PSS_OFF_RDCOUNT: rdata_reg <= rd_count_reg;
          `PSS_OFF_WRCOUNT: rdata_reg <= wr_count_reg;
          default: begin
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= `PSS_RESP_SLVERR;
          end
        endcase
      end else if (rvalid_reg && i_s_axi_rready) begin
        rvalid_reg  <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  assign o_s_axi_arready = arready_reg;
  assign o_s_axi_rvalid  = rvalid_reg;
  assign o_s_axi_rdata   = rdata_reg;
  assign o_s_axi_rresp   = rresp_reg;

endmodule

// File: verilog/pss_map.vh
// Purpose : Shared constants of the pipelined synchronous SRAM control block
// Assumes : Included by its bare name from every design file that needs it
// Notes   : Register offsets are byte addresses on the AXI4-Lite slave
`ifndef PSS_MAP_VH
`define PSS_MAP_VH

// ----------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------
`define PSS_ADDR_W        16
`define PSS_LANE_W        9
`define PSS_LANES         2

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define PSS_AXI_AW        8
`define PSS_OFF_CTRL      8'h00
`define PSS_OFF_STATUS    8'h04
`define PSS_OFF_RDCOUNT   8'h08
`define PSS_OFF_WRCOUNT   8'h0C

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define PSS_CTRL_ENABLE   0
`define PSS_CTRL_CLEAR    1
`define PSS_CTRL_RESET    1'h1
`define PSS_ST_SELECTED   0
`define PSS_ST_LAST_WRITE 1
`define PSS_ST_ORDER_PIN  2
`define PSS_ST_ADVANCE_PIN 3

// ----------------------------------------------------------------
// AXI response codes
// ----------------------------------------------------------------
`define PSS_RESP_OKAY     2'h0
`define PSS_RESP_SLVERR   2'h2

`endif

// File: verilog/pss_lane_ram.v
// Purpose : Byte-lane static array with a registered read port
// Assumes : Address and write enables arrive already registered
// Notes   : Read during write of the same word returns the old contents
`include "pss_map.vh"

module pss_lane_ram #(
  parameter LANE_W = `PSS_LANE_W,
  parameter LANES  = `PSS_LANES,
  parameter ADDR_W = `PSS_ADDR_W
) (
  input  wire                      i_ref_clk,
  input  wire [ADDR_W-1:0]         i_addr,
  input  wire [LANES-1:0]          i_lane_we,
  input  wire [LANE_W*LANES-1:0]   i_wdata,
  output wire [LANE_W*LANES-1:0]   o_rdata
);

  // ----------------------------------------------------------------
  // One array per lane so a lane write never disturbs its neighbour
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : lane
      reg [LANE_W-1:0] mem_reg [0:(1<<ADDR_W)-1];
      reg [LANE_W-1:0] rd_reg;
      // Registered read keeps the array inside the pipeline stage
      always @(posedge i_ref_clk) begin
        if (i_lane_we[g]) begin
          mem_reg[i_addr] <= i_wdata[g*LANE_W +: LANE_W];
        end
        rd_reg <= mem_reg[i_addr];
      end
      assign o_rdata[g*LANE_W +: LANE_W] = rd_reg;
    end
  endgenerate

endmodule

// File: dv/pss_sram_ctrl_asserts.sv
// Purpose: Checks on the data pins and bus handshakes of pss_sram_ctrl
// Assumes: One clock; the register enable is only dropped while the pins idle
// Notes  : Selection is tracked from the pins, a strobe-free cycle reuses it
`include "pss_map.vh"
module pss_sram_ctrl_chk #(
  parameter LANE_W = `PSS_LANE_W,
  parameter LANES  = `PSS_LANES
) (
  input wire                    i_ref_clk,
  input wire                    i_srst,
  input wire [LANE_W*LANES-1:0] o_dq,
  input wire                    o_dq_oe,
  input wire                    i_output_enable_n,
  input wire                    i_all_lanes_write_n,
  input wire                    i_write_qualifier_n,
  input wire [LANES-1:0]        i_byte_lane_write_n,
  input wire                    i_select_one_n,
  input wire                    i_select_two,
  input wire                    i_select_three_n,
  input wire                    i_cpu_addr_strobe_n,
  input wire                    i_ctrl_addr_strobe_n,
  input wire                    o_s_axi_bvalid,
  input wire                    i_s_axi_bready,
  input wire                    o_s_axi_arready,
  input wire                    o_s_axi_rvalid,
  input wire                    i_s_axi_rready
);
  // ----------------------
  // Cycle decode
  // ----------------------
  reg  sel_reg;
  wire chip_en  = !i_select_one_n && i_select_two && !i_select_three_n;
  wire strobe   = !i_cpu_addr_strobe_n || !i_ctrl_addr_strobe_n;
  wire sel_next = strobe ? chip_en : sel_reg;
  wire wr       = !i_all_lanes_write_n || (!i_write_qualifier_n && !(&i_byte_lane_write_n));
  wire wr_sel   = sel_next && wr;
  wire rd_sel   = sel_next && !wr;
  // Selection held between strobes, cleared by reset
  always @(posedge i_ref_clk) begin
    sel_reg <= i_srst ? 1'b0 : sel_next;
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  // ----------------------
  // Properties
  // ----------------------
  wr_blocks_oe_a: assert property (wr_sel |-> ##2 !o_dq_oe)
    else $error("data bus driven after a write");
  oe_source_a: assert property (o_dq_oe |-> !$past(i_output_enable_n) && $past(rd_sel, 3))
    else $error("data bus driven without a read");
  dq_source_a: assert property (!$stable(o_dq) |-> $past(rd_sel, 3))
    else $error("read data changed without a read");
  desel_quiet_a: assert property (strobe && !chip_en |-> ##3 !o_dq_oe)
    else $error("deselected cycle drove the bus");
  wr_keeps_dq_a: assert property (wr_sel |-> ##3 $stable(o_dq))
    else $error("write cycle changed read data");
  bresp_once_a: assert property (o_s_axi_bvalid && i_s_axi_bready |=> !o_s_axi_bvalid)
    else $error("write response repeated");
  rresp_once_a: assert property (o_s_axi_rvalid && i_s_axi_rready |=> !o_s_axi_rvalid)
    else $error("read response repeated");
  one_read_a: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
    else $error("read address taken during a response");
  cover property (wr_sel);
  cover property (rd_sel ##2 !i_output_enable_n ##1 o_dq_oe);
  cover property (strobe && !chip_en);
endmodule

bind pss_sram_ctrl pss_sram_ctrl_chk #(.LANE_W(LANE_W), .LANES(LANES)) pss_sram_ctrl_chk_i (
  .i_ref_clk, .i_srst, .o_dq, .o_dq_oe, .i_output_enable_n, .i_all_lanes_write_n,
  .i_write_qualifier_n, .i_byte_lane_write_n, .i_select_one_n, .i_select_two, .i_select_three_n,
  .i_cpu_addr_strobe_n, .i_ctrl_addr_strobe_n, .o_s_axi_bvalid, .i_s_axi_bready,
  .o_s_axi_arready, .o_s_axi_rvalid, .i_s_axi_rready);

// File: dv/pss_cache_model.sv
// Purpose: Cache controller model driving the SRAM pins, one access per clock
// Assumes: Non-burst wiring, ctrl strobe held low so every edge loads an address
// Notes  : Pins hold between calls, so callers end a burst with an idle cycle
module pss_cache_model (
  input  wire         i_ref_clk,
  output logic [15:0] o_addr,
  output logic [17:0] o_dq,
  output logic        o_output_enable_n,
  output logic [3:0]  o_write_n,
  output logic [2:0]  o_select,
  output logic        o_cpu_addr_strobe_n,
  output logic        o_ctrl_addr_strobe_n,
  output logic        o_burst_advance_n,
  output logic        o_burst_order_select_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------
  // Tie levels and idle
  // ----------------------
  initial begin
    o_cpu_addr_strobe_n    = 1'b1;
    o_ctrl_addr_strobe_n   = 1'b0;
    o_burst_advance_n      = 1'b1;
    o_burst_order_select_n = 1'b0;
    o_select               = 3'h3;
    o_write_n              = 4'hF;
    o_addr                 = 16'h0000;
    o_dq                   = 18'h15555;
    o_output_enable_n      = 1'b0;
  end
  // One cycle; oe_keep leaves output enable low on a write, only when asked
  task automatic cyc(input logic [2:0] sel, input logic [3:0] wn, input logic [15:0] a,
                     input logic [17:0] d, input logic oe_keep);
    logic wr;
    wr = !wn[3] || (!wn[2] && wn[1:0] != 2'h3);
    @(posedge i_ref_clk);
    o_select          <= sel;
    o_write_n         <= wn;
    o_addr            <= a;
    o_dq              <= wr ? d : ~o_dq; // Released bus never keeps the old value
    o_output_enable_n <= wr && !oe_keep;
  endtask
endmodule

// File: dv/pss_sram_ctrl_tb.sv
// Purpose: Self-checking bench for pss_sram_ctrl
// Assumes: Expected data come from a shadow array fed by the observed pins
// Notes  : Only written addresses are read, the array is not reset
`include "pss_map.vh"
module pss_sram_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_ref_clk = 1'b0, i_srst = 1'b1, en = 1'b1, oeh = 1'b1;
  logic        i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0, i_s_axi_bready = 1'b0;
  logic        i_s_axi_arvalid = 1'b0, i_s_axi_rready = 1'b0;
  logic [7:0]  i_s_axi_awaddr = 8'h00, i_s_axi_araddr = 8'h00;
  logic [31:0] i_s_axi_wdata = 32'h0;
  logic [2:0]  rdh = 3'h0, wrh = 3'h0;
  logic [17:0] sh [0:65535];
  logic [17:0] dh [0:2];
  logic [15:0] at [0:7];
  integer      n_mismatch = 0, cmp_count = 0, seed = 32'hBD618214;
  wire  [15:0] i_addr;
  wire  [17:0] i_dq, o_dq;
  wire  [3:0]  wn;
  wire  [2:0]  sl;
  wire  [1:0]  o_s_axi_bresp, o_s_axi_rresp;
  wire  [31:0] o_s_axi_rdata;
  wire         i_output_enable_n, i_cpu_addr_strobe_n, i_ctrl_addr_strobe_n, i_burst_advance_n;
  wire         i_burst_order_select_n, o_dq_oe, o_s_axi_awready, o_s_axi_wready;
  wire         o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
  always #25 i_ref_clk = ~i_ref_clk;
  pss_cache_model pss_cache_model_i (.i_ref_clk, .o_addr(i_addr), .o_dq(i_dq), .o_output_enable_n(i_output_enable_n),
    .o_write_n(wn), .o_select(sl), .o_cpu_addr_strobe_n(i_cpu_addr_strobe_n),
    .o_ctrl_addr_strobe_n(i_ctrl_addr_strobe_n), .o_burst_advance_n(i_burst_advance_n),
    .o_burst_order_select_n(i_burst_order_select_n));
  pss_sram_ctrl pss_sram_ctrl_i (.i_ref_clk, .i_srst, .i_addr, .i_dq, .o_dq, .o_dq_oe, .i_output_enable_n,
    .i_all_lanes_write_n(wn[3]), .i_write_qualifier_n(wn[2]), .i_byte_lane_write_n(wn[1:0]),
    .i_select_one_n(sl[2]), .i_select_two(sl[1]), .i_select_three_n(sl[0]), .i_cpu_addr_strobe_n,
    .i_ctrl_addr_strobe_n, .i_burst_advance_n, .i_burst_order_select_n, .i_s_axi_awaddr,
    .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wdata, .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid,
    .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr,
    .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid,
    .i_s_axi_rready);
  // ----------------------
  // Checking helpers
  // ----------------------
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Lane merge of a write into the shadow array
  function automatic logic [17:0] merge(input logic [17:0] old, d, input logic [3:0] w);
    merge = old;
    if (!w[3] || (!w[2] && !w[0])) merge[8:0] = d[8:0];
    if (!w[3] || (!w[2] && !w[1])) merge[17:9] = d[17:9];
  endfunction
  // Pin monitor: a read captured at edge E shows after edge E+2
  always @(posedge i_ref_clk) begin
    logic s, w;
    s = en && sl == 3'h2;
    w = !wn[3] || (!wn[2] && wn[1:0] != 2'h3);
    if (i_srst) begin
      rdh = 3'h0;
      wrh = 3'h0;
      oeh = 1'b1;
    end else begin
      chk({31'h0, o_dq_oe}, {31'h0, rdh[2] && !wrh[1] && !oeh}, "bus enable");
      if (rdh[2]) chk({14'h0, o_dq}, {14'h0, dh[2]}, "read data");
      dh[2] = dh[1];
      dh[1] = dh[0];
      dh[0] = sh[i_addr];
      rdh = {rdh[1:0], s && !w};
      wrh = {wrh[1:0], s && w};
      oeh = i_output_enable_n;
      if (s && w) sh[i_addr] = merge(sh[i_addr], i_dq, wn);
    end
  end
  // ----------------------
  // Register bus master
  // ----------------------
  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    @(posedge i_ref_clk);
    i_s_axi_awaddr <= a;
    i_s_axi_araddr <= a;
    i_s_axi_wdata <= d;
    i_s_axi_awvalid <= wr;
    i_s_axi_wvalid <= wr;
    i_s_axi_bready <= wr;
    i_s_axi_arvalid <= !wr;
    i_s_axi_rready <= !wr;
    for (n = 0; n < 20; n++) begin
      @(posedge i_ref_clk);
      if (o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
      if (o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
      if (o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
      if (wr ? o_s_axi_bvalid : o_s_axi_rvalid) break;
    end
    i_s_axi_bready <= 1'b0;
    i_s_axi_rready <= 1'b0;
    if (n == 20) begin
      n_mismatch++;
      test_done;
    end else begin
      chk({30'h0, wr ? o_s_axi_bresp : o_s_axi_rresp}, {30'h0, r}, "response");
      if (!wr) chk(o_s_axi_rdata, d, "register");
    end
  endtask
  task automatic idle(input int n);
    repeat (n) pss_cache_model_i.cyc(3'h3, 4'hF, 16'h0, 18'h0, 1'b0);
  endtask
  // ----------------------
  // Main sequence
  // ----------------------
  initial begin
    logic [31:0] r;
    for (int i = 0; i < 8; i++) at[i] = 16'($random(seed));
    at[0] = 16'h0000;
    at[7] = 16'hFFFF;
    repeat (16) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    axi(0, `PSS_OFF_CTRL, 32'h1, `PSS_RESP_OKAY);
    axi(0, `PSS_OFF_STATUS, 32'h8, `PSS_RESP_OKAY);
    axi(0, 8'h10, 32'h0, `PSS_RESP_SLVERR);
    axi(1, 8'h14, 32'hF, `PSS_RESP_SLVERR);
    axi(1, `PSS_OFF_CTRL, 32'h3, `PSS_RESP_OKAY);
    $display("registers done");
    for (int i = 0; i < 8; i++) pss_cache_model_i.cyc(3'h2, 4'h7, at[i], 18'($random(seed)), 1'b0);
    for (int i = 0; i < 8; i++) pss_cache_model_i.cyc(3'h2, 4'hF, at[i], 18'h0, 1'b0);
    idle(4);
    axi(0, `PSS_OFF_WRCOUNT, 32'h8, `PSS_RESP_OKAY);
    axi(0, `PSS_OFF_RDCOUNT, 32'h8, `PSS_RESP_OKAY);
    // Clear with nonzero counts, pins idle so nothing recounts
    axi(1, `PSS_OFF_CTRL, 32'h3, `PSS_RESP_OKAY);
    axi(0, `PSS_OFF_RDCOUNT, 32'h0, `PSS_RESP_OKAY);
    axi(0, `PSS_OFF_WRCOUNT, 32'h0, `PSS_RESP_OKAY);
    $display("stream done");
    // Random mix with every select pattern and oe left low on some writes
    for (int k = 0; k < 400; k++) begin
      r = $random(seed);
      pss_cache_model_i.cyc(r[5] ? 3'h2 : r[2:0], r[9:6], at[r[12:10]], 18'($random(seed)), r[13] & r[14]);
    end
    idle(4);
    $display("random done");
    axi(1, `PSS_OFF_CTRL, 32'h0, `PSS_RESP_OKAY);
    en = 1'b0;
    for (int i = 0; i < 6; i++) pss_cache_model_i.cyc(3'h2, 4'hF, at[i], 18'h0, 1'b0);
    idle(1);
    i_srst <= 1'b1;
    repeat (16) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    en = 1'b1;
    axi(0, `PSS_OFF_CTRL, 32'h1, `PSS_RESP_OKAY);
    for (int i = 0; i < 8; i++) pss_cache_model_i.cyc(3'h2, 4'hF, at[i], 18'h0, 1'b0);
    idle(4);
    $display("disable and reset done");
    test_done;
  end
endmodule
